// ==== osc_pkg.sv ====
// shared constants of the open-loop speed curve: register map, field positions,
// reset values and timing figures. assumes a 50 MHz core clock.
`default_nettype none
package osc_pkg;
   // core clock
   localparam int unsigned CLK_HZ = 50_000_000;
   // register offsets, byte registers
   localparam logic [7:0] OFS_HALT = 8'h02;
   localparam logic [7:0] OFS_LAUNCH = 8'h03;
   localparam logic [7:0] OFS_KNEE = 8'h04;
   localparam logic [7:0] OFS_CEILING = 8'h05;
   localparam logic [7:0] OFS_FLOOR = 8'h06;
   localparam logic [7:0] OFS_HYST = 8'h07;
   localparam logic [7:0] OFS_GAIN1_LO = 8'h08;
   localparam logic [7:0] OFS_GAIN1_HI = 8'h09;
   localparam logic [7:0] OFS_GAIN2_LO = 8'h0a;
   localparam logic [7:0] OFS_GAIN2_HI = 8'h0b;
   localparam logic [7:0] OFS_CMD_LO = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h0d;
   localparam logic [7:0] OFS_OUT_LO = 8'h0e;
   localparam logic [7:0] OFS_CONTROL = 8'h0f;
   // field positions
   localparam int unsigned BIT_KEEP_RUNNING = 7;
   localparam int unsigned BIT_LINEAR_ABOVE = 1;
   localparam int unsigned BIT_FULL_AT_ZERO = 0;
   localparam int unsigned BIT_SOURCE_ANALOG = 0;
   // value of every register after reset
   localparam logic [7:0] REG_RESET = 8'h00;
   // duty scale: 512 steps is 100 %
   localparam int unsigned DUTY_BITS = 9;
   localparam logic [9:0] DUTY_FULL = 10'h200;
   localparam logic [9:0] CEILING_BASE = 10'h101;
   // gains are fixed point with 10 fraction bits
   localparam int unsigned GAIN_FRAC = 10;
   // command pwm: 9 bits held up to this frequency, sample tick derived from it
   localparam int unsigned CMD_FULLRES_HZ = 20_000;
   localparam int unsigned CMD_SAMPLE_DIV = CLK_HZ / (CMD_FULLRES_HZ * 512);
   // lowest command frequency; no edge for two such periods means 0 % or 100 %
   localparam int unsigned CMD_MIN_HZ = 1_000;
   localparam int unsigned CMD_TIMEOUT_CYC = 2 * (CLK_HZ / CMD_MIN_HZ);
   // output pwm: 9 bits at this frequency, prescale rounded down
   localparam int unsigned OUT_PWM_HZ = 23_400;
   localparam int unsigned OUT_PRESCALE = CLK_HZ / (OUT_PWM_HZ * 512);
   // ratio unit states
   typedef enum logic [1:0] {
      OSC_DIV_IDLE = 2'b01,
      OSC_DIV_RUN = 2'b10
   } osc_div_state_t;
endpackage : osc_pkg
`default_nettype wire

// ==== osc_ratio.sv ====
// serial ratio unit: quot = num * 512 / den, saturating at 512 when num >= den.
// assumes start is a one-cycle pulse on the core clock; a start while busy is ignored.
`timescale 1ns/1ps
`default_nettype none
module osc_ratio #(
   parameter int unsigned W = 17
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // request
   input wire logic start,
   input wire logic [W-1:0] num,
   input wire logic [W-1:0] den,
   // answer
   output logic busy,
   output logic done,
   output logic [9:0] quot
);
   import osc_pkg::*;
   osc_div_state_t state, next_state;
   logic [W:0] rem, next_rem;
   logic [W-1:0] dv, next_dv;
   logic [8:0] q, next_q;
   logic [3:0] cnt, next_cnt;
   logic full, next_full;
   logic next_done;
   logic [9:0] next_quot;
   logic [W:0] shifted;

   // one fraction bit per cycle, nine cycles per request
   always_comb begin
      next_state = state;
      next_rem = rem;
      next_dv = dv;
      next_q = q;
      next_cnt = cnt;
      next_full = full;
      next_done = 1'b0;
      next_quot = quot;
      shifted = {rem[W-1:0], 1'b0};
      case (state)
         OSC_DIV_IDLE: begin
            if (start) begin
               next_rem = {1'b0, num};
               next_dv = den;
               next_full = (num >= den);
               next_q = 9'h000;
               next_cnt = 4'h9;
               next_state = OSC_DIV_RUN;
            end
         end
         OSC_DIV_RUN: begin
            if (shifted >= {1'b0, dv}) begin
               next_rem = shifted - {1'b0, dv};
               next_q = {q[7:0], 1'b1};
            end else begin
               next_rem = shifted;
               next_q = {q[7:0], 1'b0};
            end
            next_cnt = cnt - 4'h1;
            if (cnt == 4'h1) begin
               next_done = 1'b1;
               next_quot = full ? DUTY_FULL : {1'b0, next_q};
               next_state = OSC_DIV_IDLE;
            end
         end
         default: next_state = OSC_DIV_IDLE;
      endcase
   end

   // state registers
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= OSC_DIV_IDLE;
         rem <= '0;
         dv <= '0;
         q <= 9'h000;
         cnt <= 4'h0;
         full <= 1'b0;
         done <= 1'b0;
         quot <= 10'h000;
      end else begin
         state <= next_state;
         rem <= next_rem;
         dv <= next_dv;
         q <= next_q;
         cnt <= next_cnt;
         full <= next_full;
         done <= next_done;
         quot <= next_quot;
      end
   end

   assign busy = (state == OSC_DIV_RUN);
endmodule : osc_ratio
`default_nettype wire

// ==== osc_pwm_gen.sv ====
// output pwm generator: 9-bit duty, one count step every PRESCALE clocks.
// assumes duty in 1/512 steps; 512 drives the output high for the whole period.
`timescale 1ns/1ps
`default_nettype none
module osc_pwm_gen #(
   parameter int unsigned PRESCALE = osc_pkg::OUT_PRESCALE
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // duty in, pwm out
   input wire logic [9:0] duty,
   output logic pwm
);
   import osc_pkg::*;
   logic [7:0] pre, next_pre;
   logic [8:0] cnt, next_cnt;
   logic next_pwm;

   // period counter and compare
   always_comb begin
      next_pre = pre + 8'h01;
      next_cnt = cnt;
      if (pre == 8'(PRESCALE - 1)) begin
         next_pre = 8'h00;
         next_cnt = cnt + 9'h001;
      end
      next_pwm = ({1'b0, cnt} < duty);
   end

   // registers
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pre <= 8'h00;
         cnt <= 9'h000;
         pwm <= 1'b0;
      end else begin
         pre <= next_pre;
         cnt <= next_cnt;
         pwm <= next_pwm;
      end
   end
endmodule : osc_pwm_gen
`default_nettype wire

// ==== osc_speed_curve.sv ====
// open-loop speed curve: speed command (pwm pin or analog code) to output pwm duty.
// assumes a 50 MHz clock, adc codes from logic on the same clock, a plain register port.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module osc_speed_curve #(
   parameter int unsigned CMD_TIMEOUT = osc_pkg::CMD_TIMEOUT_CYC,
   parameter int unsigned ADC_W = 10,
   parameter logic [ADC_W-1:0] ADC_LOW = '0,
   parameter logic [ADC_W-1:0] ADC_HIGH = '1
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // speed command
   input wire logic speed_command,
   input wire logic [ADC_W-1:0] adc_code,
   input wire logic adc_valid,
   // output pwm
   output logic pwm_out
);
   import osc_pkg::*;

   localparam int unsigned CW = 17;

   // clamp a difference at zero
   function automatic logic [9:0] sub0(input logic [9:0] a, input logic [9:0] b);
      return (a > b) ? (a - b) : 10'h000;
   endfunction : sub0

   // one straight segment: base + span * gain / 1024, saturating at 100 %
   function automatic logic [9:0] seg(input logic [9:0] base, input logic [9:0] span,
                                      input logic [13:0] gain);
      logic [23:0] p;
      logic [14:0] s;
      p = {14'h0000, span} * {10'h000, gain};
      s = {5'h00, base} + {1'b0, p[23:GAIN_FRAC]};
      return (s > {5'h00, DUTY_FULL}) ? DUTY_FULL : s[9:0];
   endfunction : seg

   // registers seen by software
   logic [7:0] halt_threshold_and_keep_running, launch_threshold, knee_point;
   logic [7:0] ceiling_threshold, floor_output_level, ceiling_hysteresis;
   logic [7:0] first_gain_low, first_gain_high_and_options;
   logic [7:0] second_gain_low, second_gain_high, control;
   logic [7:0] next_halt, next_launch, next_knee, next_ceiling, next_floor, next_hyst;
   logic [7:0] next_g1_lo, next_g1_hi, next_g2_lo, next_g2_hi, next_control;
   logic [7:0] next_rdata;

   // block state
   logic [9:0] cmd_duty, next_cmd_duty;
   logic [9:0] out_duty, next_out_duty;
   logic run, next_run;
   logic pass, next_pass;

   // command capture state
   logic sync1, sync2, level;
   logic [7:0] tick_cnt, next_tick_cnt;
   logic [CW-1:0] high_cnt, next_high_cnt, per_cnt, next_per_cnt;
   logic [CW-1:0] idle_cnt, next_idle_cnt;
   logic div_start;
   logic [CW-1:0] div_num, div_den;
   logic div_busy, div_done;
   logic [9:0] div_quot;

   // decoded fields
   logic source_analog, keep_running, linear_above_ceiling, full_at_zero_command;
   logic [13:0] first_gain, second_gain;
   logic [9:0] start_lvl, stop_lvl, ceil_lvl, knee_lvl, floor_lvl, hys_lvl;
   logic knee_used;
   logic [9:0] knee_out, max_curve, max_out, x, curve;

   assign source_analog = control[BIT_SOURCE_ANALOG];
   assign keep_running = halt_threshold_and_keep_running[BIT_KEEP_RUNNING];
   assign linear_above_ceiling = first_gain_high_and_options[BIT_LINEAR_ABOVE];
   assign full_at_zero_command = first_gain_high_and_options[BIT_FULL_AT_ZERO];
   assign first_gain = {first_gain_high_and_options[7:2], first_gain_low};
   assign second_gain = {second_gain_high[7:2], second_gain_low};

   // register writes
   always_comb begin
      next_halt = halt_threshold_and_keep_running;
      next_launch = launch_threshold;
      next_knee = knee_point;
      next_ceiling = ceiling_threshold;
      next_floor = floor_output_level;
      next_hyst = ceiling_hysteresis;
      next_g1_lo = first_gain_low;
      next_g1_hi = first_gain_high_and_options;
      next_g2_lo = second_gain_low;
      next_g2_hi = second_gain_high;
      next_control = control;
      if (reg_write) begin
         case (reg_addr)
            OFS_HALT: next_halt = reg_wdata;
            OFS_LAUNCH: next_launch = reg_wdata;
            OFS_KNEE: next_knee = reg_wdata;
            OFS_CEILING: next_ceiling = reg_wdata;
            OFS_FLOOR: next_floor = reg_wdata;
            OFS_HYST: next_hyst = {4'h0, reg_wdata[3:0]};
            OFS_GAIN1_LO: next_g1_lo = reg_wdata;
            OFS_GAIN1_HI: next_g1_hi = reg_wdata;
            OFS_GAIN2_LO: next_g2_lo = reg_wdata;
            OFS_GAIN2_HI: next_g2_hi = {reg_wdata[7:1], 1'b0};
            OFS_CONTROL: next_control = {7'h00, reg_wdata[BIT_SOURCE_ANALOG]};
            default: next_control = control;
         endcase
      end
   end

   // read data, valid the cycle after the read strobe; unmapped reads give zero
   always_comb begin
      next_rdata = 8'h00;
      if (reg_read) begin
         case (reg_addr)
            OFS_HALT: next_rdata = halt_threshold_and_keep_running;
            OFS_LAUNCH: next_rdata = launch_threshold;
            OFS_KNEE: next_rdata = knee_point;
            OFS_CEILING: next_rdata = ceiling_threshold;
            OFS_FLOOR: next_rdata = floor_output_level;
            OFS_HYST: next_rdata = ceiling_hysteresis;
            OFS_GAIN1_LO: next_rdata = first_gain_low;
            OFS_GAIN1_HI: next_rdata = first_gain_high_and_options;
            OFS_GAIN2_LO: next_rdata = second_gain_low;
            OFS_GAIN2_HI: next_rdata = second_gain_high;
            OFS_CMD_LO: next_rdata = cmd_duty[7:0];
            OFS_STATUS: next_rdata = {pass, run, out_duty[9:8], 2'b00, cmd_duty[9:8]};
            OFS_OUT_LO: next_rdata = out_duty[7:0];
            OFS_CONTROL: next_rdata = control;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // register file
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         halt_threshold_and_keep_running <= REG_RESET;
         launch_threshold <= REG_RESET;
         knee_point <= REG_RESET;
         ceiling_threshold <= REG_RESET;
         floor_output_level <= REG_RESET;
         ceiling_hysteresis <= REG_RESET;
         first_gain_low <= REG_RESET;
         first_gain_high_and_options <= REG_RESET;
         second_gain_low <= REG_RESET;
         second_gain_high <= REG_RESET;
         control <= REG_RESET;
         reg_rdata <= 8'h00;
      end else begin
         halt_threshold_and_keep_running <= next_halt;
         launch_threshold <= next_launch;
         knee_point <= next_knee;
         ceiling_threshold <= next_ceiling;
         floor_output_level <= next_floor;
         ceiling_hysteresis <= next_hyst;
         first_gain_low <= next_g1_lo;
         first_gain_high_and_options <= next_g1_hi;
         second_gain_low <= next_g2_lo;
         second_gain_high <= next_g2_hi;
         control <= next_control;
         reg_rdata <= next_rdata;
      end
   end

   // command pin synchroniser, then one more stage for edge detection
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         level <= 1'b0;
      end else begin
         sync1 <= speed_command;
         sync2 <= sync1;
         level <= sync2;
      end
   end

   // count high and period samples at a fixed tick, so a fast command has fewer steps
   always_comb begin
      next_tick_cnt = tick_cnt + 8'h01;
      next_high_cnt = high_cnt;
      next_per_cnt = per_cnt;
      next_idle_cnt = idle_cnt;
      if (tick_cnt == 8'(CMD_SAMPLE_DIV - 1)) begin
         next_tick_cnt = 8'h00;
         if (per_cnt != '1) begin
            next_per_cnt = per_cnt + CW'(1);
            next_high_cnt = high_cnt + {{(CW-1){1'b0}}, level};
         end
      end
      if (sync2 != level) begin
         next_idle_cnt = '0;
      end else if (idle_cnt != CW'(CMD_TIMEOUT)) begin
         next_idle_cnt = idle_cnt + CW'(1);
      end
      if ((sync2 && !level) || (idle_cnt == CW'(CMD_TIMEOUT))) begin
         next_high_cnt = '0;
         next_per_cnt = '0;
      end
   end

   // the ratio unit serves the selected source: pwm period ends or analog samples
   always_comb begin
      if (source_analog) begin
         div_start = adc_valid;
         div_num = (adc_code > ADC_LOW) ? CW'(adc_code - ADC_LOW) : '0;
         div_den = CW'(ADC_HIGH - ADC_LOW);
      end else begin
         div_start = sync2 && !level && (per_cnt != '0);
         div_num = high_cnt;
         div_den = per_cnt;
      end
   end

   osc_ratio #(
      .W(CW)
   ) u_ratio (
      .clock(clock),
      .rstn(rstn),
      .start(div_start),
      .num(div_num),
      .den(div_den),
      .busy(div_busy),
      .done(div_done),
      .quot(div_quot)
   );

   // command duty: ratio result, or a steady pin level after the timeout
   always_comb begin
      next_cmd_duty = cmd_duty;
      if (div_done) begin
         next_cmd_duty = div_quot;
      end else if (!source_analog && !div_busy && idle_cnt == CW'(CMD_TIMEOUT)) begin
         next_cmd_duty = level ? DUTY_FULL : 10'h000;
      end
   end

   // decoded levels, all in 1/512 of full duty
   always_comb begin
      start_lvl = {2'b00, launch_threshold};
      stop_lvl = {2'b00, halt_threshold_and_keep_running[6:0], 1'b0};
      ceil_lvl = {2'b00, ceiling_threshold} + CEILING_BASE;
      knee_lvl = {1'b0, knee_point, 1'b0};
      floor_lvl = {2'b00, floor_output_level};
      hys_lvl = {5'h00, ceiling_hysteresis[3:0], 1'b0} + 10'h002;
      knee_used = (knee_point != 8'h00);
   end

   // piecewise curve evaluated at the command clamped to [launch, ceiling]
   always_comb begin
      x = (cmd_duty > ceil_lvl) ? ceil_lvl : cmd_duty;
      knee_out = seg(floor_lvl, sub0(knee_lvl, start_lvl), first_gain);
      if (knee_used && x > knee_lvl) begin
         curve = seg(knee_out, sub0(x, knee_lvl), second_gain);
      end else begin
         curve = seg(floor_lvl, sub0(x, start_lvl), first_gain);
      end
      if (knee_used && ceil_lvl > knee_lvl) begin
         max_curve = seg(knee_out, sub0(ceil_lvl, knee_lvl), second_gain);
      end else begin
         max_curve = seg(floor_lvl, sub0(ceil_lvl, start_lvl), first_gain);
      end
      max_out = linear_above_ceiling ? DUTY_FULL : max_curve;
   end

   // run and pass-through flags with their hysteresis
   always_comb begin
      next_run = run;
      if (cmd_duty > start_lvl) begin
         next_run = 1'b1;
      end else if (cmd_duty <= stop_lvl) begin
         next_run = 1'b0;
      end
      next_pass = 1'b0;
      if (linear_above_ceiling) begin
         if (cmd_duty >= ceil_lvl) begin
            next_pass = 1'b1;
         end else if ({1'b0, cmd_duty} + {1'b0, hys_lvl} < {1'b0, ceil_lvl}) begin
            next_pass = 1'b0;
         end else begin
            next_pass = pass;
         end
      end
   end

   // output duty selection
   always_comb begin
      if (keep_running && full_at_zero_command && cmd_duty <= stop_lvl) begin
         next_out_duty = max_out;
      end else if (keep_running && cmd_duty <= start_lvl) begin
         next_out_duty = floor_lvl;
      end else if (cmd_duty == 10'h000) begin
         next_out_duty = full_at_zero_command ? max_out : 10'h000;
      end else if (cmd_duty <= stop_lvl) begin
         next_out_duty = 10'h000;
      end else if (cmd_duty <= start_lvl) begin
         next_out_duty = run ? floor_lvl : 10'h000;
      end else if (pass) begin
         next_out_duty = cmd_duty;
      end else begin
         next_out_duty = curve;
      end
   end

   // command and curve state
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tick_cnt <= 8'h00;
         high_cnt <= '0;
         per_cnt <= '0;
         idle_cnt <= '0;
         cmd_duty <= 10'h000;
         out_duty <= 10'h000;
         run <= 1'b0;
         pass <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         high_cnt <= next_high_cnt;
         per_cnt <= next_per_cnt;
         idle_cnt <= next_idle_cnt;
         cmd_duty <= next_cmd_duty;
         out_duty <= next_out_duty;
         run <= next_run;
         pass <= next_pass;
      end
   end

   // output pwm at 9 bits per period
   osc_pwm_gen #(
      .PRESCALE(OUT_PRESCALE)
   ) u_pwm (
      .clock(clock),
      .rstn(rstn),
      .duty(out_duty),
      .pwm(pwm_out)
   );
endmodule : osc_speed_curve
`default_nettype wire

// ==== osc_speed_curve_props.sv ====
// checker of the speed curve register port, bound to the top module.
// assumes the plain register port with read data one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module osc_speed_curve_props (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   // output pwm
   input wire logic pwm_out
);
   import osc_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // read data stand only after a read strobe
   property p_idle; !reg_read |=> reg_rdata == 8'h00; endproperty
   property p_rback; reg_write && reg_addr == OFS_LAUNCH ##1 !reg_write
      ##1 reg_read && reg_addr == OFS_LAUNCH |=> reg_rdata == $past(reg_wdata, 3); endproperty
   property p_unmap; reg_read && (reg_addr < 8'h02 || reg_addr > 8'h0f) |=> reg_rdata == 8'h00;
   endproperty
   property p_hyst; reg_read && reg_addr == OFS_HYST |=> reg_rdata[7:4] == 4'h0; endproperty
   property p_g2hi; reg_read && reg_addr == OFS_GAIN2_HI |=> !reg_rdata[0]; endproperty
   property p_ctrl; reg_read && reg_addr == OFS_CONTROL |=> reg_rdata[7:1] == 7'h00; endproperty
   // duties never reach 768: their top two bits are never both set
   property p_osat; reg_read && reg_addr == OFS_STATUS |=> reg_rdata[5:4] != 2'b11
      && reg_rdata[3:2] == 2'b00; endproperty
   property p_csat; reg_read && reg_addr == OFS_STATUS |=> reg_rdata[1:0] != 2'b11; endproperty
   a_idle: assert property (p_idle) else $error("read data without read");
   a_rback: assert property (p_rback) else $error("launch readback wrong");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_hyst: assert property (p_hyst) else $error("hysteresis upper bits set");
   a_g2hi: assert property (p_g2hi) else $error("second gain bit0 set");
   a_ctrl: assert property (p_ctrl) else $error("control upper bits set");
   a_osat: assert property (p_osat) else $error("output duty above full");
   a_csat: assert property (p_csat) else $error("command duty above full");
   // main scenarios
   c_stat: cover property (reg_read && reg_addr == OFS_STATUS);
   c_rback: cover property (reg_write && reg_addr == OFS_LAUNCH ##2 reg_read);
   c_pwm: cover property ($rose(pwm_out));
endmodule : osc_speed_curve_props
bind osc_speed_curve osc_speed_curve_props u_props (.clock(clock), .rstn(rstn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rdata(reg_rdata), .pwm_out(pwm_out));
`default_nettype wire

// ==== osc_cmd_src.sv ====
// speed command source: a pwm on the pin, or a strobed adc code.
// assumes the bench sets mode, code and pwm timing between tests.
`timescale 1ns/1ps
`default_nettype none
module osc_cmd_src (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // setup
   input wire logic analog,
   input wire logic [9:0] code,
   input wire logic [15:0] high_cyc,
   input wire logic [15:0] period_cyc,
   // command out
   output logic speed_command,
   output logic [9:0] adc_code,
   output logic adc_valid
);
   logic [15:0] cnt;
   // period counter
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt <= 16'h0000;
      end else begin
         cnt <= (cnt + 16'h0001 >= period_cyc) ? 16'h0000 : cnt + 16'h0001;
      end
   end
   // pin idles low in analog mode; code is garbage outside the strobe
   assign speed_command = !analog && cnt < high_cyc;
   assign adc_valid = analog && cnt[4:0] == 5'h00;
   assign adc_code = adc_valid ? code : ~code;
endmodule : osc_cmd_src
`default_nettype wire

// ==== open_loop_speed_curve_tb.sv ====
// self-checking bench of the speed curve, analog and pin commands.
// assumes osc_cmd_src as command source and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module open_loop_speed_curve_tb;
   import osc_pkg::*;
   logic clock, rstn, reg_write, reg_read, analog, speed_command, adc_valid, pwm_out;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
   logic [9:0] code, adc_code, duty;
   logic [15:0] high_cyc, period_cyc;
   int error_cnt, tests_run, n;
   osc_speed_curve #(.CMD_TIMEOUT(1200), .ADC_W(10), .ADC_LOW(10'h000), .ADC_HIGH(10'h200)) dut (
      .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .speed_command(speed_command), .adc_code(adc_code), .adc_valid(adc_valid),
      .pwm_out(pwm_out));
   osc_cmd_src u_src (.clock(clock), .rstn(rstn), .analog(analog), .code(code),
      .high_cyc(high_cyc), .period_cyc(period_cyc), .speed_command(speed_command),
      .adc_code(adc_code), .adc_valid(adc_valid));
   // 50 MHz clock
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 rv = reg_rdata;
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      `CHK(rv, e)
   endtask : rchk
   // settle a command, then compare the output duty
   task automatic cmd(input logic [9:0] c, input logic [9:0] e);
      code <= c;
      repeat (80) @(posedge clock);
      rd(OFS_OUT_LO);
      duty[7:0] = rv;
      rd(OFS_STATUS);
      duty[9:8] = rv[5:4];
      `CHK(duty, e)
   endtask : cmd
   task automatic t_regs();
      for (int a = 2; a < 16; a++) rchk(a[7:0], REG_RESET);
      wr(OFS_GAIN2_HI, 8'hff);
      rchk(OFS_GAIN2_HI, 8'hfe);
      wr(OFS_HYST, 8'hff);
      rchk(OFS_HYST, 8'h0f);
      wr(8'h20, 8'hff);
      rchk(8'h20, 8'h00);
      wr(OFS_CONTROL, 8'hff);
      rchk(OFS_CONTROL, 8'h01);
      wr(OFS_LAUNCH, 8'd100);
      rchk(OFS_LAUNCH, 8'd100);
      wr(OFS_HALT, 8'd20);
      wr(OFS_CEILING, 8'd43);
      wr(OFS_FLOOR, 8'd50);
      wr(OFS_GAIN1_LO, 8'h00);
      wr(OFS_GAIN1_HI, 8'h10);
      wr(OFS_GAIN2_HI, 8'h00);
   endtask : t_regs
   // launch 100, halt 40, ceiling 300, floor 50, gain 1
   task automatic t_curve();
      cmd(10'd70, 10'd0);
      cmd(10'd200, 10'd150);
      cmd(10'd70, 10'd50);
      cmd(10'd40, 10'd0);
      cmd(10'd100, 10'd0);
      cmd(10'd101, 10'd51);
      cmd(10'd299, 10'd249);
      cmd(10'd450, 10'd250);
   endtask : t_curve
   task automatic t_knee();
      wr(OFS_KNEE, 8'd100);
      wr(OFS_GAIN1_HI, 8'h20);
      wr(OFS_GAIN2_HI, 8'h08);
      cmd(10'd150, 10'd150);
      cmd(10'd280, 10'd290);
      wr(OFS_KNEE, 8'd0);
      wr(OFS_GAIN1_HI, 8'h12);
      cmd(10'd280, 10'd230);
   endtask : t_knee
   // linear option with hysteresis 8, then zero and keep running cases
   task automatic t_modes();
      wr(OFS_GAIN1_HI, 8'h12);
      wr(OFS_HYST, 8'h03);
      cmd(10'd350, 10'd350);
      cmd(10'd295, 10'd295);
      cmd(10'd290, 10'd240);
      wr(OFS_GAIN1_HI, 8'h13);
      cmd(10'd0, 10'd512);
      wr(OFS_GAIN1_HI, 8'h11);
      cmd(10'd0, 10'd250);
      cmd(10'd30, 10'd0);
      wr(OFS_HALT, 8'h94);
      cmd(10'd30, 10'd250);
      wr(OFS_GAIN1_HI, 8'h10);
      cmd(10'd30, 10'd50);
      cmd(10'd90, 10'd50);
   endtask : t_modes
   // half duty on the pin, then the pin held high
   task automatic t_pin();
      wr(OFS_CONTROL, 8'h00);
      analog <= 1'b0;
      period_cyc <= 16'd2048;
      high_cyc <= 16'd1024;
      repeat (8000) @(posedge clock);
      rd(OFS_CMD_LO);
      `CHK(rv >= 8'hff || rv <= 8'h01, 1'b1)
      n = 0;
      repeat (2048) begin
         @(posedge clock);
         #1 n += int'(pwm_out);
      end
      `CHK(n >= 820 && n <= 828, 1'b1)
      high_cyc <= 16'hffff;
      repeat (1400) @(posedge clock);
      rd(OFS_STATUS);
      `CHK(rv[1:0], 2'b10)
   endtask : t_pin
   task automatic print_verdict();
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict
   // watchdog
   initial begin
      #2_000_000;
      error_cnt++;
      print_verdict();
   end
   // main sequence
   initial begin
      error_cnt = 0;
      tests_run = 0;
      {rstn, reg_write, reg_read, reg_addr, reg_wdata} = '0;
      analog = 1'b1;
      code = 10'd0;
      high_cyc = 16'd0;
      period_cyc = 16'd32;
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      t_regs();
      t_curve();
      t_knee();
      t_modes();
      t_pin();
      print_verdict();
   end
endmodule : open_loop_speed_curve_tb
`default_nettype wire
